/* File: hdl/ata_cmd_pkg.sv */
// How it works
// - Start wear-leveling when max erase count exceeds average by 255 or more.
// - SMART enable: opcode B0h, features D8h, Lba_bits_mid 4Fh.
// - SMART disable: opcode B0h, features D9h, Lba_bits_high C2h.
// - After SMART enable, SMART capabilities stay on until disabled.
// - SMART disable needs SMART on and ready; it turns SMART off.
// - Transfer count 00h means 256 sectors.
// - LBA is low, mid, high bytes plus device low nibble, 28 bits.
// - READ MULTIPLE C4h returns exactly the requested sector count.
// - READ MULTIPLE groups sectors into blocks of the configured block size.
// - READ SECTORS 20h transfers 1 to 256 sectors.
// - Read starts at the sector given by the LBA registers.
// - Data request rises before every block, even with an error.
// - One host interrupt for every data block.
// - Unrecoverable error ends the read; LBA registers get failing sector.
// - Missing address sets the address-not-found error bit.
// - Host selects device by select bit; device echoes it back.
// - SMART read: B0h with D0h, one PIO data-in block.
`default_nettype none

package ata_cmd_pkg;
    // Task file addresses
    localparam logic [2:0] ADDR_FEAT_ERR   = 3'h1;
    localparam logic [2:0] ADDR_COUNT      = 3'h2;
    localparam logic [2:0] ADDR_LBA_BITS_LOW    = 3'h3;
    localparam logic [2:0] ADDR_LBA_BITS_MID    = 3'h4;
    localparam logic [2:0] ADDR_LBA_BITS_HIGH   = 3'h5;
    localparam logic [2:0] ADDR_DRIVE      = 3'h6;
    localparam logic [2:0] ADDR_CMD_STATUS = 3'h7;
    // Opcodes and features
    localparam logic [7:0] OP_READ_SECTORS  = 8'h20;
    localparam logic [7:0] OP_READ_MULTIPLE = 8'hc4;
    localparam logic [7:0] OP_SMART         = 8'hb0;
    localparam logic [7:0] FEAT_SMART_READ  = 8'hd0;
    localparam logic [7:0] FEAT_SMART_EN    = 8'hd8;
    localparam logic [7:0] FEAT_SMART_DIS   = 8'hd9;
    localparam logic [7:0] SIG_MID          = 8'h4f;
    localparam logic [7:0] SIG_HIGH         = 8'hc2;
    // Status and error bit positions
    localparam int STS_BSY  = 7;
    localparam int STS_DRDY = 6;
    localparam int STS_DF   = 5;
    localparam int STS_DRQ  = 3;
    localparam int STS_ERR  = 0;
    localparam int ERR_UNC  = 6;
    localparam int ERR_IDNF = 4;
    localparam int ERR_ABRT = 2;
    localparam int DEV_SEL  = 4;
    // Counts
    localparam logic [8:0]  SECTORS_MAX = 9'd256;
    localparam logic [16:0] WEAR_GAP    = 17'd255;
    localparam logic [7:0]  RESET_BYTE  = 8'h00;
endpackage : ata_cmd_pkg

`default_nettype wire

/* File: hdl/wear_trigger.sv */
`default_nettype none

module wear_trigger
    import ata_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Erase statistics
    input  wire logic [15:0] maxErase,
    input  wire logic [15:0] avgErase,
    // Trigger
    output logic             wearStart
);
    logic overGap;
    logic overGapFf;

    assign overGap = {1'b0, maxErase} >= ({1'b0, avgErase} + WEAR_GAP);

    always_ff @(posedge clk) begin
        if (rst) begin
            overGapFf <= 1'b0;
            wearStart <= 1'b0;
        end else begin
            overGapFf <= overGap;
            wearStart <= overGap && !overGapFf;
        end
    end
endmodule : wear_trigger

`default_nettype wire

/* File: hdl/ata_cmd_engine.sv */
`default_nettype none

module ata_cmd_engine
    import ata_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Task file port
    input  wire logic        tfWrEn,
    input  wire logic [2:0]  tfAddr,
    input  wire logic [7:0]  tfWrData,
    output logic      [7:0]  tfRdData,
    // Device setup
    input  wire logic        ownDev,
    input  wire logic [7:0]  blockSectors,
    // Media side
    output logic             mediaReq,
    output logic      [27:0] mediaLba,
    output logic             mediaSmart,
    input  wire logic        mediaDone,
    input  wire logic        mediaUnc,
    input  wire logic        mediaIdnf,
    // Host data handshake
    output logic             drq,
    output logic             intrq,
    input  wire logic        hostBlockAck,
    // Wear and SMART state
    input  wire logic [15:0] maxErase,
    input  wire logic [15:0] avgErase,
    output logic             wearStart,
    output logic             smartOn
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_XFER} state_e;

    state_e      state_ff;
    logic [7:0]  featFf;
    logic [7:0]  countFf;
    logic [7:0]  lbaLowFf;
    logic [7:0]  lbaMidFf;
    logic [7:0]  lbaHighFf;
    logic [7:0]  driveFf;
    logic [7:0]  errFf;
    logic        busyFf;
    logic        errStsFf;
    logic        termFf;
    logic [27:0] curLbaFf;
    logic [8:0]  remainFf;
    logic [7:0]  inBlkFf;
    logic [7:0]  blkSizeFf;
    logic        cmdWr;
    logic        cmdGo;
    logic        sigOk;
    logic        mediaBad;
    logic [7:0]  nxt_inBlk;
    logic [7:0]  statusByte;

    // Command acceptance
    assign cmdWr    = tfWrEn && (tfAddr == ADDR_CMD_STATUS);
    assign cmdGo    = cmdWr && !busyFf && !drq && (driveFf[DEV_SEL] == ownDev);
    assign sigOk    = (lbaMidFf == SIG_MID) && (lbaHighFf == SIG_HIGH);
    assign mediaBad = mediaUnc || mediaIdnf;
    assign nxt_inBlk = inBlkFf + 8'h01;
    assign mediaLba = curLbaFf;

    // Status byte layout
    always_comb begin
        statusByte = 8'h00;
        statusByte[STS_BSY]  = busyFf;
        statusByte[STS_DRDY] = !busyFf;
        statusByte[STS_DF]   = 1'b0;
        statusByte[STS_DRQ]  = drq;
        statusByte[STS_ERR]  = errStsFf;
    end

    // Task file registers
    always_ff @(posedge clk) begin
        if (rst) begin
            featFf    <= RESET_BYTE;
            countFf   <= RESET_BYTE;
            lbaLowFf  <= RESET_BYTE;
            lbaMidFf  <= RESET_BYTE;
            lbaHighFf <= RESET_BYTE;
            driveFf   <= RESET_BYTE;
        end else if (state_ff == ST_WAIT && mediaDone && mediaBad) begin
            lbaLowFf      <= curLbaFf[7:0];
            lbaMidFf      <= curLbaFf[15:8];
            lbaHighFf     <= curLbaFf[23:16];
            driveFf[3:0]  <= curLbaFf[27:24];
        end else if (tfWrEn && !busyFf) begin
            unique case (tfAddr)
                ADDR_FEAT_ERR: featFf    <= tfWrData;
                ADDR_COUNT:    countFf   <= tfWrData;
                ADDR_LBA_BITS_LOW:  lbaLowFf  <= tfWrData;
                ADDR_LBA_BITS_MID:  lbaMidFf  <= tfWrData;
                ADDR_LBA_BITS_HIGH: lbaHighFf <= tfWrData;
                ADDR_DRIVE:    driveFf   <= tfWrData;
                default:       featFf    <= featFf;
            endcase
        end
    end

    // Task file read back
    always_ff @(posedge clk) begin
        if (rst) begin
            tfRdData <= RESET_BYTE;
        end else begin
            unique case (tfAddr)
                ADDR_FEAT_ERR:   tfRdData <= errFf;
                ADDR_COUNT:      tfRdData <= countFf;
                ADDR_LBA_BITS_LOW:    tfRdData <= lbaLowFf;
                ADDR_LBA_BITS_MID:    tfRdData <= lbaMidFf;
                ADDR_LBA_BITS_HIGH:   tfRdData <= lbaHighFf;
                ADDR_DRIVE:      tfRdData <= driveFf;
                ADDR_CMD_STATUS: tfRdData <= statusByte;
                default:         tfRdData <= RESET_BYTE;
            endcase
        end
    end

    // SMART enable state
    always_ff @(posedge clk) begin
        if (rst) begin
            smartOn <= 1'b0;
        end else if (cmdGo && tfWrData == OP_SMART && sigOk) begin
            if (featFf == FEAT_SMART_EN) begin
                smartOn <= 1'b1;
            end else if (featFf == FEAT_SMART_DIS && smartOn) begin
                smartOn <= 1'b0;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff   <= ST_IDLE;
            busyFf     <= 1'b0;
            drq        <= 1'b0;
            intrq      <= 1'b0;
            errFf      <= RESET_BYTE;
            errStsFf   <= 1'b0;
            termFf     <= 1'b0;
            mediaReq   <= 1'b0;
            mediaSmart <= 1'b0;
            curLbaFf   <= 28'h0000000;
            remainFf   <= 9'h000;
            inBlkFf    <= 8'h00;
            blkSizeFf  <= 8'h01;
        end else begin
            intrq    <= 1'b0;
            mediaReq <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (cmdGo) begin
                        errFf    <= RESET_BYTE;
                        errStsFf <= 1'b0;
                        termFf   <= 1'b0;
                        inBlkFf  <= 8'h00;
                        curLbaFf <= {driveFf[3:0], lbaHighFf, lbaMidFf, lbaLowFf};
                        remainFf <= (countFf == 8'h00) ? SECTORS_MAX : {1'b0, countFf};
                        mediaSmart <= 1'b0;
                        blkSizeFf  <= 8'h01;
                        unique case (tfWrData)
                            OP_READ_SECTORS: begin
                                busyFf   <= 1'b1;
                                state_ff <= ST_FETCH;
                            end
                            OP_READ_MULTIPLE: begin
                                busyFf    <= 1'b1;
                                blkSizeFf <= (blockSectors == 8'h00) ? 8'h01 : blockSectors;
                                state_ff  <= ST_FETCH;
                            end
                            OP_SMART: begin
                                if (sigOk && featFf == FEAT_SMART_READ && smartOn) begin
                                    busyFf     <= 1'b1;
                                    mediaSmart <= 1'b1;
                                    remainFf   <= 9'h001;
                                    state_ff   <= ST_FETCH;
                                end else if (sigOk && (featFf == FEAT_SMART_EN
                                        || (featFf == FEAT_SMART_DIS && smartOn))) begin
                                    errStsFf <= 1'b0;
                                end else begin
                                    errFf[ERR_ABRT] <= 1'b1;
                                    errStsFf        <= 1'b1;
                                end
                            end
                            default: begin
                                errFf[ERR_ABRT] <= 1'b1;
                                errStsFf        <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_FETCH: begin
                    mediaReq <= 1'b1;
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mediaDone) begin
                        if (mediaBad) begin
                            errFf[ERR_UNC]  <= mediaUnc;
                            errFf[ERR_IDNF] <= mediaIdnf;
                            errStsFf        <= 1'b1;
                            termFf          <= 1'b1;
                            busyFf          <= 1'b0;
                            drq             <= 1'b1;
                            intrq           <= 1'b1;
                            inBlkFf         <= 8'h00;
                            state_ff        <= ST_XFER;
                        end else begin
                            curLbaFf <= curLbaFf + 28'h0000001;
                            remainFf <= remainFf - 9'h001;
                            if (remainFf == 9'h001 || nxt_inBlk == blkSizeFf) begin
                                busyFf   <= 1'b0;
                                drq      <= 1'b1;
                                intrq    <= 1'b1;
                                inBlkFf  <= 8'h00;
                                state_ff <= ST_XFER;
                            end else begin
                                inBlkFf  <= nxt_inBlk;
                                state_ff <= ST_FETCH;
                            end
                        end
                    end
                end
                ST_XFER: begin
                    if (hostBlockAck) begin
                        drq <= 1'b0;
                        if (termFf || remainFf == 9'h000) begin
                            mediaSmart <= 1'b0;
                            state_ff   <= ST_IDLE;
                        end else begin
                            busyFf   <= 1'b1;
                            state_ff <= ST_FETCH;
                        end
                    end
                end
            endcase
        end
    end

    // Wear-leveling trigger
    wear_trigger wear_trigger_inst (
        .clk       (clk),
        .rst       (rst),
        .maxErase  (maxErase),
        .avgErase  (avgErase),
        .wearStart (wearStart)
    );

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DRQ_RISE_INTR: assert property ($rose(drq) |-> intrq)
        else $error("drq rose without interrupt");
    AST_INTR_WITH_DRQ: assert property (intrq |-> drq && !busyFf)
        else $error("interrupt outside a data block");
    AST_BUSY_DRQ_EXCL: assert property (!(busyFf && drq))
        else $error("busy and drq together");
    AST_SMART_ENABLE: assert property (
        cmdGo && tfWrData == OP_SMART && sigOk && featFf == FEAT_SMART_EN
        |=> smartOn && !errStsFf && !busyFf)
        else $error("smart enable not taken");
    AST_SMART_DISABLE: assert property (
        cmdGo && tfWrData == OP_SMART && sigOk && featFf == FEAT_SMART_DIS && smartOn
        |=> !smartOn && !errStsFf)
        else $error("smart disable not taken");
    AST_COUNT_ZERO: assert property (
        cmdGo && tfWrData == OP_READ_SECTORS && countFf == 8'h00
        |=> remainFf == SECTORS_MAX && busyFf)
        else $error("zero count not 256");
    AST_SMART_ABORT: assert property (
        cmdGo && tfWrData == OP_SMART && !sigOk
        |=> errFf[ERR_ABRT] && errStsFf && !busyFf && smartOn == $past(smartOn))
        else $error("bad smart signature not aborted");
    AST_ERR_LOADS_LBA: assert property (
        state_ff == ST_WAIT && mediaDone && mediaBad
        |=> {driveFf[3:0], lbaHighFf, lbaMidFf, lbaLowFf} == $past(curLbaFf)
            && errStsFf && drq)
        else $error("failing address not loaded");
    AST_ERR_FLAG: assert property (
        !busyFf && state_ff == ST_IDLE && errFf != 8'h00 |-> errStsFf)
        else $error("error bit without status error");
    AST_WEAR_CAUSE: assert property (
        wearStart |-> {1'b0, $past(maxErase)} >= {1'b0, $past(avgErase)} + WEAR_GAP)
        else $error("wear start without erase gap");
    AST_MEDIA_ONE_PULSE: assert property (mediaReq |=> !mediaReq && busyFf)
        else $error("media request not single pulse");

    COV_READ_DONE: cover property (state_ff == ST_XFER && hostBlockAck && remainFf == 9'h000);
    COV_READ_ERROR: cover property (state_ff == ST_WAIT && mediaDone && mediaBad);
    COV_SMART_ON: cover property ($rose(smartOn));
    COV_MULTI_BLOCK: cover property (state_ff == ST_WAIT && mediaDone && inBlkFf != 8'h00);
endmodule : ata_cmd_engine

`default_nettype wire

/* File: tb/host_media_model.sv */
`default_nettype none

module host_media_model
    import ata_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench control
    input  wire logic        clr,
    input  wire logic        slow,
    input  wire logic [8:0]  errAt,
    input  wire logic [1:0]  errKind,
    // Media side
    input  wire logic        mediaReq,
    input  wire logic [27:0] mediaLba,
    output logic             mediaDone,
    output logic             mediaUnc,
    output logic             mediaIdnf,
    // Host side
    input  wire logic        drq,
    input  wire logic        intrq,
    output logic             hostBlockAck,
    // Counts
    output var int           reqCount,
    output var int           blocks,
    output var int           intrs,
    output logic      [27:0] firstLba
);
    logic [2:0] pend;
    logic [2:0] waitCnt;
    logic       junk;
    logic       fail;

    // Sector fetch, failure injected at sector errAt
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            pend      <= 3'h0;
            mediaDone <= 1'b0;
            reqCount  <= 0;
            firstLba  <= 28'h0;
            junk      <= 1'b0;
        end else begin
            mediaDone <= 1'b0;
            junk      <= ~junk;
            if (mediaReq) begin
                pend     <= slow ? 3'h4 : 3'h1;
                reqCount <= reqCount + 1;
                if (reqCount == 0) firstLba <= mediaLba;
            end else if (pend == 3'h1) begin
                pend      <= 3'h0;
                mediaDone <= 1'b1;
            end else if (pend != 3'h0) begin
                pend <= pend - 3'h1;
            end
        end
    end

    // Flags mean nothing outside mediaDone
    assign fail      = (reqCount == int'(errAt) + 1);
    assign mediaUnc  = mediaDone ? (fail && errKind[0]) : junk;
    assign mediaIdnf = mediaDone ? (fail && errKind[1]) : ~junk;

    // Host takes each block, data of a failed block not trusted
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            hostBlockAck <= 1'b0;
            waitCnt      <= 3'h0;
            blocks       <= 0;
            intrs        <= 0;
        end else begin
            hostBlockAck <= 1'b0;
            if (intrq) intrs <= intrs + 1;
            if (drq && !hostBlockAck) begin
                if (waitCnt >= (slow ? 3'h5 : 3'h0)) begin
                    hostBlockAck <= 1'b1;
                    waitCnt      <= 3'h0;
                    blocks       <= blocks + 1;
                end else begin
                    waitCnt <= waitCnt + 3'h1;
                end
            end
        end
    end
endmodule : host_media_model

`default_nettype wire

/* File: tb/ata_cmd_engine_bench.sv */
`default_nettype none

module ata_cmd_engine_bench;
    import ata_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, tfWrEn, ownDev, mediaReq, mediaSmart, mediaDone;
    logic        mediaUnc, mediaIdnf, drq, intrq, hostBlockAck, wearStart;
    logic        smartOn, clr, slow;
    logic [2:0]  tfAddr;
    logic [7:0]  tfWrData, tfRdData, blockSectors;
    logic [27:0] mediaLba, firstLba;
    logic [15:0] maxErase, avgErase;
    logic [8:0]  errAt;
    logic [1:0]  errKind;
    int          reqCount, blocks, intrs, wearCnt, n_mismatch, checks_done, smartReqs;
    localparam logic [27:0] SIG = {4'h0, SIG_HIGH, SIG_MID, 8'h00};
    localparam logic [8:0]  NOERR = 9'h1ff;

    ata_cmd_engine ata_cmd_engine_inst (.clk(clk), .rst(rst), .tfWrEn(tfWrEn),
        .tfAddr(tfAddr), .tfWrData(tfWrData), .tfRdData(tfRdData), .ownDev(ownDev),
        .blockSectors(blockSectors), .mediaReq(mediaReq), .mediaLba(mediaLba),
        .mediaSmart(mediaSmart), .mediaDone(mediaDone), .mediaUnc(mediaUnc),
        .mediaIdnf(mediaIdnf), .drq(drq), .intrq(intrq), .hostBlockAck(hostBlockAck),
        .maxErase(maxErase), .avgErase(avgErase), .wearStart(wearStart), .smartOn(smartOn));
    host_media_model host_media_model_inst (.clk(clk), .rst(rst), .clr(clr), .slow(slow),
        .errAt(errAt), .errKind(errKind), .mediaReq(mediaReq), .mediaLba(mediaLba),
        .mediaDone(mediaDone), .mediaUnc(mediaUnc), .mediaIdnf(mediaIdnf), .drq(drq),
        .intrq(intrq), .hostBlockAck(hostBlockAck), .reqCount(reqCount),
        .blocks(blocks), .intrs(intrs), .firstLba(firstLba));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) if (wearStart === 1'b1) wearCnt++;
    always @(posedge clk) if (mediaReq === 1'b1 && mediaSmart === 1'b1) smartReqs++;

    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        tfAddr = a;
        tfWrData = d;
        tfWrEn = 1'b1;
        @(posedge clk);
        #1 tfWrEn = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        tfAddr = a;
        @(posedge clk);
        #1 d = tfRdData;
    endtask : rd

    task automatic cmd(input logic [7:0] op, input logic [7:0] feat, input logic [7:0] cnt,
                       input logic [27:0] lba, input logic dev, input logic [8:0] at,
                       input logic [1:0] kind, input int nSect, input int nBlk,
                       input logic [7:0] expErr);
        logic [7:0]  d;
        logic [27:0] f;
        int          idle;
        errAt = at;
        errKind = kind;
        smartReqs = 0;
        clr = 1'b1;
        @(posedge clk);
        #1 clr = 1'b0;
        wr(ADDR_FEAT_ERR, feat);
        wr(ADDR_COUNT, cnt);
        wr(ADDR_LBA_BITS_LOW, lba[7:0]);
        wr(ADDR_LBA_BITS_MID, lba[15:8]);
        wr(ADDR_LBA_BITS_HIGH, lba[23:16]);
        wr(ADDR_DRIVE, {3'b111, dev, lba[27:24]});
        wr(ADDR_CMD_STATUS, op);
        idle = 0;
        for (int i = 0; i < 4000 && idle < 3; i++) begin
            rd(ADDR_CMD_STATUS, d);
            idle = (d[STS_BSY] === 1'b0 && d[STS_DRQ] === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 3) begin
            n_mismatch++;
            $display("MISMATCH at %0t: command never finished", $time);
        end
        chk(reqCount, nSect);
        chk(blocks, nBlk);
        chk(intrs, nBlk);
        chk(smartReqs, (op == OP_SMART) ? nSect : 0);
        chk(d, (expErr == 8'h00) ? 8'h40 : 8'h41);
        if (expErr != 8'h00) begin
            rd(ADDR_FEAT_ERR, d);
            chk(d, expErr);
        end
        f = lba + 28'(at);
        if (kind != 2'h0) begin
            rd(ADDR_LBA_BITS_LOW, d);
            chk(d, f[7:0]);
            rd(ADDR_LBA_BITS_MID, d);
            chk(d, f[15:8]);
            rd(ADDR_LBA_BITS_HIGH, d);
            chk(d, f[23:16]);
            rd(ADDR_DRIVE, d);
            chk({d[4], d[3:0]}, {dev, f[27:24]});
        end else if (op != OP_SMART && nSect > 0) begin
            chk(firstLba, lba);
        end
    endtask : cmd

    task automatic reset_values;
        logic [7:0] d;
        for (int a = 1; a < 7; a++) begin
            rd(3'(a), d);
            chk(d, 8'h00);
        end
        rd(ADDR_CMD_STATUS, d);
        chk(d, 8'h40);
        chk(smartOn, 1'b0);
    endtask : reset_values

    task automatic smart_seq;
        cmd(OP_SMART, FEAT_SMART_EN, 8'h00, {4'h0, SIG_HIGH, 16'h0}, 0, NOERR, 0, 0, 0, 8'h04);
        cmd(OP_SMART, FEAT_SMART_READ, 8'h00, SIG, 0, NOERR, 0, 0, 0, 8'h04);
        cmd(OP_SMART, FEAT_SMART_EN, 8'h00, SIG, 0, NOERR, 0, 0, 0, 8'h00);
        chk(smartOn, 1'b1);
        cmd(OP_SMART, FEAT_SMART_READ, 8'h00, SIG, 0, NOERR, 0, 1, 1, 8'h00);
        cmd(OP_SMART, 8'hd5, 8'h00, SIG, 0, NOERR, 0, 0, 0, 8'h04);
        chk(smartOn, 1'b1);
        cmd(OP_SMART, FEAT_SMART_DIS, 8'h00, SIG, 0, NOERR, 0, 0, 0, 8'h00);
        chk(smartOn, 1'b0);
        cmd(OP_SMART, FEAT_SMART_DIS, 8'h00, SIG, 0, NOERR, 0, 0, 0, 8'h04);
        cmd(8'h91, 0, 8'h01, 28'h0000000, 0, NOERR, 0, 0, 0, 8'h04);
    endtask : smart_seq

    task automatic read_seq;
        cmd(OP_READ_SECTORS, 0, 8'h03, 28'ha5c3e17, 0, NOERR, 0, 3, 3, 0);
        blockSectors = 8'h02;
        slow = 1'b1;
        cmd(OP_READ_MULTIPLE, 0, 8'h05, 28'h0fffffe, 0, NOERR, 0, 5, 3, 0);
        slow = 1'b0;
        cmd(OP_READ_SECTORS, 0, 8'h00, 28'h1234567, 0, NOERR, 0, 256, 256, 0);
        blockSectors = 8'h08;
        cmd(OP_READ_MULTIPLE, 0, 8'h00, 28'h0000100, 0, NOERR, 0, 256, 32, 0);
    endtask : read_seq

    task automatic error_seq;
        blockSectors = 8'h02;
        cmd(OP_READ_MULTIPLE, 0, 8'h06, 28'h30000fe, 0, 9'h3, 1, 4, 2, 8'h40);
        cmd(OP_READ_SECTORS, 0, 8'h04, 28'h7654321, 0, 9'h2, 2, 3, 3, 8'h10);
    endtask : error_seq

    task automatic devsel_seq;
        logic [7:0] d;
        // Ignored command leaves the last error standing
        cmd(OP_READ_SECTORS, 0, 8'h01, 28'h9000001, 1, NOERR, 0, 0, 0, 8'h10);
        rd(ADDR_DRIVE, d);
        chk(d, 8'hf9);
    endtask : devsel_seq

    task automatic wear_seq;
        wearCnt = 0;
        maxErase = 16'd354;
        repeat (4) @(posedge clk);
        #1 chk(wearCnt, 0);
        maxErase = 16'd355;
        repeat (6) @(posedge clk);
        #1 chk(wearCnt, 1);
    endtask : wear_seq

    initial begin
        {tfWrEn, tfAddr, tfWrData, ownDev, clr, slow, errKind} = '0;
        {rst, blockSectors, errAt, maxErase, avgErase} = {1'b1, 8'h01, NOERR, 16'd100, 16'd100};
        {wearCnt, n_mismatch, checks_done} = '0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        reset_values();
        smart_seq();
        read_seq();
        error_seq();
        devsel_seq();
        wear_seq();
        results();
    end

    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule : ata_cmd_engine_bench

`default_nettype wire
